// >>> inc/adcrt_defines.svh
// Offsets, field positions, reset values and timing counts of the converter
`ifndef ADCRT_DEFINES_SVH
`define ADCRT_DEFINES_SVH

// Register byte offsets on the bus
`define ADCRT_CTRL_OFS 8'h00
`define ADCRT_RES_OFS 8'h04

// Control register fields
`define ADCRT_CTRL_CH_LSB 0
`define ADCRT_CTRL_MODE_LSB 4
`define ADCRT_CTRL_ALIGN_BIT 6
`define ADCRT_CTRL_START_BIT 7
`define ADCRT_CTRL_BUSY_BIT 8
`define ADCRT_CTRL_SMP_LSB 12
`define ADCRT_CTRL_TMG_LSB 14
`define ADCRT_CTRL_RST 16'h0000

// Result register fields
`define ADCRT_RES_CH_LSB 12
`define ADCRT_RES_RST 10'h000

// Conversion mode codes
`define ADCRT_MODE_FIX_SINGLE 2'h0
`define ADCRT_MODE_FIX_CONT 2'h1
`define ADCRT_MODE_SCAN_SINGLE 2'h2
`define ADCRT_MODE_SCAN_CONT 2'h3

// Timing: basic clock divide at code 0, shortest sample in basic clocks
`define ADCRT_DIV_MIN 4
`define ADCRT_SAMPLE_MIN_TBC 8

// Bus answers
`define ADCRT_RESP_OKAY 2'h0
`define ADCRT_RESP_SLVERR 2'h2

`endif

// >>> inc/adcrt_pkg.sv
// Types shared by the converter control files
package adcrt_pkg;

	// Approximation engine states
	typedef enum logic [1:0] {
		ADCRT_S_IDLE,
		ADCRT_S_SAMPLE,
		ADCRT_S_CONV
	} adcrt_sar_state_t;

	// Register select after address decode
	typedef enum logic [1:0] {
		ADCRT_SEL_NONE,
		ADCRT_SEL_CTRL,
		ADCRT_SEL_RES
	} adcrt_sel_t;

endpackage : adcrt_pkg

// >>> logic/adcrt_sar_core.sv
// Successive approximation engine: sample phase, then one bit per tick
`timescale 1ns/1ns
`include "adcrt_defines.svh"

module adcrt_sar_core #(
	parameter int RES_W = 10
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic tick,
	input wire logic go,
	input wire logic [6:0] samp_len,
	input wire logic comp,
	output logic busy,
	output logic done,
	output logic sample,
	output logic [RES_W-1:0] result,
	output logic [RES_W-1:0] dac
);

	localparam int BIT_W = $clog2(RES_W);

	adcrt_pkg::adcrt_sar_state_t state_q;
	logic [6:0] cnt_q;
	logic [BIT_W-1:0] bit_q;
	logic [RES_W-1:0] dac_q;
	logic [RES_W-1:0] res_q;
	logic done_q;
	logic sample_q;

	// Trial bit kept when the input sits above the trial level
	wire [RES_W-1:0] bit_mask = RES_W'(1) << bit_q;
	wire [RES_W-1:0] keep_w = comp ? dac_q : (dac_q & ~bit_mask);
	wire [RES_W-1:0] trial_w = keep_w | (bit_mask >> 1);

	assign busy = (state_q != adcrt_pkg::ADCRT_S_IDLE);
	assign done = done_q;
	assign sample = sample_q;
	assign result = res_q;
	assign dac = dac_q;

	// Sequence; the result word changes only at the last bit
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state_q <= adcrt_pkg::ADCRT_S_IDLE;
			cnt_q <= 7'h00;
			bit_q <= '0;
			dac_q <= '0;
			res_q <= '0;
			done_q <= 1'b0;
			sample_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				adcrt_pkg::ADCRT_S_IDLE: begin
					if (go) begin
						state_q <= adcrt_pkg::ADCRT_S_SAMPLE;
						sample_q <= 1'b1;
						cnt_q <= samp_len;
					end
				end
				adcrt_pkg::ADCRT_S_SAMPLE: begin
					if (tick) begin
						if (cnt_q == 7'h01) begin
							sample_q <= 1'b0;
							state_q <= adcrt_pkg::ADCRT_S_CONV;
							bit_q <= BIT_W'(RES_W - 1);
							dac_q <= RES_W'(1) << (RES_W - 1);
						end else begin
							cnt_q <= cnt_q - 7'h01;
						end
					end
				end
				adcrt_pkg::ADCRT_S_CONV: begin
					if (tick) begin
						if (bit_q == '0) begin
							res_q <= keep_w; // [R1] [R4] [R9]
							dac_q <= keep_w;
							done_q <= 1'b1;
							state_q <= adcrt_pkg::ADCRT_S_IDLE;
						end else begin
							dac_q <= trial_w;
							bit_q <= bit_q - BIT_W'(1);
						end
					end
				end
				default: state_q <= adcrt_pkg::ADCRT_S_IDLE;
			endcase
		end
	end

endmodule : adcrt_sar_core

// >>> logic/adcrt_ctrl_top.sv
// Converter control and result registers behind an AXI4-Lite slave
// Functional notes
// R1: Result is always ten bits wide in result bits 9:0, no alignment choice.
// R2: Software keeps control bit 6 at zero; it is reserved.
// R3: Earliest step only: bit 6 may be set after end of init, never before.
// R4: With bit 6 zero, the two result LSBs carry real conversion data.
// R5: Result MSB always sits at bit 9, whatever bit 6 holds.
// R6: Control bits 15:14 select the basic clock divided from the system clock.
// R7: Ten-bit resolution; fixed, auto scan and continuous modes by software.
// R8: Control bits 13:12 set sample time; code 0 gives eight basic clocks.
// R9: Result register changes only when a conversion completes.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "adcrt_defines.svh"

module adcrt_ctrl_top #(
	parameter int ADDR_W = 8,
	parameter int RES_W = 10,
	parameter int CH_W = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic comp_in,
	output logic conv_sample,
	output logic [CH_W-1:0] conv_chan,
	output logic [RES_W-1:0] conv_dac
);

	// Address decode shared by both channels
	function automatic adcrt_pkg::adcrt_sel_t reg_sel(
		input logic [ADDR_W-1:0] a
	);
		if (a == ADDR_W'(`ADCRT_CTRL_OFS))
			return adcrt_pkg::ADCRT_SEL_CTRL;
		else if (a == ADDR_W'(`ADCRT_RES_OFS))
			return adcrt_pkg::ADCRT_SEL_RES;
		else
			return adcrt_pkg::ADCRT_SEL_NONE;
	endfunction : reg_sel

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [15:0] ctrl_q;
	logic [RES_W-1:0] res_q;
	logic [CH_W-1:0] res_ch_q, cur_ch_q;
	logic [1:0] cur_mode_q;
	logic run_q, go_q, tick_q;
	logic [5:0] div_cnt_q;
	logic comp_s1_q, comp_s2_q;
	logic sar_busy, sar_done;
	logic [RES_W-1:0] sar_result;

	// Write path: address and data are taken together
	wire wr_start = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
	wire wr_take = awready_q & s_axi_awvalid & s_axi_wvalid;
	wire adcrt_pkg::adcrt_sel_t wr_sel = reg_sel(s_axi_awaddr);
	wire ctrl_wr = wr_take & (wr_sel == adcrt_pkg::ADCRT_SEL_CTRL);
	wire rd_start = s_axi_arvalid & ~arready_q & ~rvalid_q;
	wire rd_take = arready_q & s_axi_arvalid;
	wire adcrt_pkg::adcrt_sel_t rd_sel = reg_sel(s_axi_araddr);

	// Control fields
	wire [CH_W-1:0] ctl_ch = ctrl_q[`ADCRT_CTRL_CH_LSB +: CH_W];
	wire [1:0] ctl_mode = ctrl_q[`ADCRT_CTRL_MODE_LSB +: 2];
	wire ctl_start = ctrl_q[`ADCRT_CTRL_START_BIT];
	wire [1:0] ctl_smp = ctrl_q[`ADCRT_CTRL_SMP_LSB +: 2];
	wire [1:0] ctl_tmg = ctrl_q[`ADCRT_CTRL_TMG_LSB +: 2];

	// Basic clock and sample length from the timing fields
	wire [5:0] div_len = 6'(`ADCRT_DIV_MIN) << ctl_tmg; // [R6]
	wire [6:0] samp_len = 7'(`ADCRT_SAMPLE_MIN_TBC) << ctl_smp; // [R8]

	// Sequencer decisions; mode and channel are taken at launch and at each continuous repeat
	wire launch = ctl_start & ~run_q & ~go_q & ~sar_busy;
	wire scan_more = cur_mode_q[1] & (cur_ch_q != '0); // [R7]
	wire cont_more = cur_mode_q[0] & ctl_start; // [R7]
	wire hw_stop = sar_done & ~scan_more & ~cur_mode_q[0];
	wire sw_start_set = ctrl_wr & s_axi_wstrb[0] &
		s_axi_wdata[`ADCRT_CTRL_START_BIT];

	// Read view: bit 6 has no effect on where the result sits
	wire [15:0] ctrl_view = {ctrl_q[15:12], 3'h0, run_q, ctrl_q[7:0]};
	wire [31:0] res_view = {16'h0000, res_ch_q, 2'h0, res_q}; // [R1] [R5]
	wire [31:0] rd_mux = (rd_sel == adcrt_pkg::ADCRT_SEL_CTRL) ?
		{16'h0000, ctrl_view} :
		(rd_sel == adcrt_pkg::ADCRT_SEL_RES) ? res_view : 32'h00000000;

	// Comparator pin passes two flops before use
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			comp_s1_q <= 1'b0;
			comp_s2_q <= 1'b0;
		end else begin
			comp_s1_q <= comp_in;
			comp_s2_q <= comp_s1_q;
		end
	end

	// Write channel handshake and response
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `ADCRT_RESP_OKAY;
		end else begin
			awready_q <= wr_start;
			wready_q <= wr_start;
			if (wr_take) begin
				awready_q <= 1'b0;
				wready_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wr_sel == adcrt_pkg::ADCRT_SEL_NONE) ?
					`ADCRT_RESP_SLVERR : `ADCRT_RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read channel handshake and data capture
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `ADCRT_RESP_OKAY;
		end else begin
			arready_q <= rd_start;
			if (rd_take) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= (rd_sel == adcrt_pkg::ADCRT_SEL_NONE) ?
					`ADCRT_RESP_SLVERR : `ADCRT_RESP_OKAY;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Control register; a software start beats the hardware clear
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_q <= `ADCRT_CTRL_RST;
		end else begin
			if (ctrl_wr & s_axi_wstrb[0])
				ctrl_q[7:0] <= s_axi_wdata[7:0];
			if (ctrl_wr & s_axi_wstrb[1])
				ctrl_q[15:12] <= s_axi_wdata[15:12];
			if (hw_stop & ~sw_start_set)
				ctrl_q[`ADCRT_CTRL_START_BIT] <= 1'b0;
		end
	end

	// Basic clock tick; the divide follows the timing field live
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			div_cnt_q <= 6'h00;
			tick_q <= 1'b0;
		end else if (div_cnt_q >= div_len - 6'h01) begin
			div_cnt_q <= 6'h00;
			tick_q <= 1'b1; // [R6]
		end else begin
			div_cnt_q <= div_cnt_q + 6'h01;
			tick_q <= 1'b0;
		end
	end

	// Conversion sequencer: fixed, scan down to channel 0, or repeat
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			run_q <= 1'b0;
			go_q <= 1'b0;
			cur_ch_q <= '0;
			cur_mode_q <= `ADCRT_MODE_FIX_SINGLE;
		end else begin
			go_q <= 1'b0;
			if (launch) begin
				run_q <= 1'b1;
				go_q <= 1'b1;
				cur_ch_q <= ctl_ch;
				cur_mode_q <= ctl_mode;
			end else if (sar_done) begin
				if (scan_more) begin
					cur_ch_q <= cur_ch_q - CH_W'(1); // [R7]
					go_q <= 1'b1;
				end else if (cont_more) begin
					cur_ch_q <= ctl_ch;
					cur_mode_q <= ctl_mode;
					go_q <= 1'b1;
				end else begin
					run_q <= 1'b0;
				end
			end
		end
	end

	// Result register loads only on completion
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			res_q <= `ADCRT_RES_RST;
			res_ch_q <= '0;
		end else if (sar_done) begin
			res_q <= sar_result; // [R1] [R4] [R9]
			res_ch_q <= cur_ch_q;
		end
	end

	adcrt_sar_core #(
		.RES_W(RES_W)
	) u_sar (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.tick(tick_q),
		.go(go_q),
		.samp_len(samp_len),
		.comp(comp_s2_q),
		.busy(sar_busy),
		.done(sar_done),
		.sample(conv_sample),
		.result(sar_result),
		.dac(conv_dac)
	);

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign conv_chan = cur_ch_q;

	// Checks on result, timing and sequencing
	sequence s_scan_done;
		sar_done && cur_mode_q[1] && (cur_ch_q != '0);
	endsequence

	sequence s_single_end;
		sar_done && (cur_mode_q == `ADCRT_MODE_FIX_SINGLE) && !ctrl_wr;
	endsequence

	chk_result_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		!sar_done |=> $stable(res_q)) // [R9]
		else $error("result changed without a completed conversion");

	// Held result must match the engine's final code on the converter side
	chk_result_load: assert property (@(posedge clk_sys) disable iff (!nrst)
		sar_done |=> res_q == conv_dac) // [R1]
		else $error("result not loaded from the finished conversion");

	chk_lsb_kept: assert property (@(posedge clk_sys) disable iff (!nrst)
		sar_done |=> res_q[1:0] == $past(sar_result[1:0])) // [R4]
		else $error("result low bits not kept");

	chk_msb_pos: assert property (@(posedge clk_sys) disable iff (!nrst)
		rd_take && rd_sel == adcrt_pkg::ADCRT_SEL_RES
		|=> s_axi_rdata[9:0] == $past(res_q)
		&& s_axi_rdata[11:10] == 2'h0) // [R5]
		else $error("result field misplaced on read");

	chk_tick_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
		tick_q |=> !tick_q [*3]) // [R6]
		else $error("basic clock faster than the least divide");

	chk_sample_len: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(conv_sample) |-> conv_sample [*8]) // [R8]
		else $error("sample phase shorter than eight cycles");

	chk_scan_step: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_scan_done |=> cur_ch_q == $past(cur_ch_q) - CH_W'(1) ##0 go_q) // [R7]
		else $error("scan did not step to the next lower channel");

	chk_single_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_single_end |=> !ctl_start && !run_q) // [R7]
		else $error("single conversion did not stop");

endmodule : adcrt_ctrl_top

// >>> tb/adcrt_ctrl_top_tb_top.sv
// Self-checking bench for the converter control and result registers
`timescale 1ns/1ns

module adcrt_ctrl_top_tb_top;
	logic clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, comp_in, conv_sample;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, prev, c;
	logic [3:0] s_axi_wstrb, conv_chan;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [9:0] conv_dac, target;
	int err_total, total_checks, seed, len, last_len, p, n;

	adcrt_ctrl_top adcrt_ctrl_top_i (.*);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Comparator stand-in: analog input sits at target, so the code converges
	always @(posedge clk_sys) comp_in <= ((target >= conv_dac) === 1'b1);

	// Length of the last sample phase in system clocks
	always @(posedge clk_sys) begin
		if (conv_sample === 1'b1) len <= len + 1;
		else if (len != 0) begin
			last_len <= len;
			len <= 0;
		end
	end

	function automatic int slen(input int k, input int s);
		return (8 << s) * (4 << k);
	endfunction : slen

	function automatic logic [31:0] rexp(input logic [3:0] ch,
		input logic [9:0] v);
		return {16'h0000, ch, 2'b00, v};
	endfunction : rexp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize

	// Both channels offered together; bready stays high for the whole run
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge clk_sys); while (s_axi_awready !== 1'b1 && ++k < 99);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1 && ++k < 99);
		rsp = s_axi_bresp;
		if (k >= 99) err_total++;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int k;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1 && ++k < 99);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1 && ++k < 99);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		if (k >= 99) err_total++;
	endtask : rdr

	// Poll until both start and busy have dropped
	task automatic idle;
		int k;
		k = 0;
		do rdr(8'h00); while (rd[8:7] !== 2'b00 && ++k < 900);
		if (k >= 900) err_total++;
	endtask : idle

	initial begin
		repeat (60000) @(posedge clk_sys);
		err_total++;
		summarize;
	end

	initial begin
		seed = 32'h211c4cd9;
		nrst = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{target, err_total, total_checks} = 0;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		// Reset values, unmapped place and read-only result
		rdr(8'h00);
		chk(rd, 32'h0);
		rdr(8'h04);
		chk(rd, 32'h0);
		rdr(8'h0c);
		chk({rsp, rd}, {2'h2, 32'h0});
		wr(8'h0c, 32'hffff);
		chk(rsp, 2'h2);
		wr(8'h04, 32'h03ff);
		chk(rsp, 2'h0);
		rdr(8'h04);
		chk(rd, 32'h0);
		prev = 32'h0;
		// Every timing and sample code, fixed single on channel i
		// Bit 6 stays clear, except once long after init to show it moves nothing
		for (int i = 0; i < 4; i++) begin
			target = (i == 0) ? 10'h3ff : (i == 3) ? 10'h201 : 10'($random(seed));
			target[0] = 1'b1;
			c = (i << 14) | ((3 - i) << 12) | 32'h80 | i;
			if (i == 3) c[6] = 1'b1;
			wr(8'h00, c);
			rdr(8'h04);
			chk(rd, prev);
			chk(conv_chan, 4'(i));
			idle;
			chk(conv_dac, target);
			rdr(8'h04);
			prev = rexp(4'(i), target);
			chk(rd, prev);
			n = slen(i, 3 - i);
			p = 4 << i;
			chk(32'(last_len >= n - p && last_len <= n + p), 32'h1);
			rdr(8'h00);
			chk(rd[15:12], c[15:12]);
		end
		// All four modes from channel 1; scan ends on channel 0
		for (int m = 0; m < 4; m++) begin
			target = 10'($random(seed));
			wr(8'h00, (m << 4) | 32'h81);
			if (m[0]) begin
				repeat (900) @(posedge clk_sys);
				rdr(8'h00);
				chk(rd[7], 1'b1);
				wr(8'h00, (m << 4) | 32'h01);
			end
			idle;
			rdr(8'h04);
			chk(rd, rexp(m[1] ? 4'h0 : 4'h1, target));
			chk(conv_chan, m[1] ? 4'h0 : 4'h1);
		end
		summarize;
	end
endmodule : adcrt_ctrl_top_tb_top
